// file: logic/mac_consts.svh
// constants for the multiplier accumulator: widths, bit positions, map
`ifndef MAC_CONSTS_SVH
`define MAC_CONSTS_SVH
`define MAC_OPND_W      16
`define MAC_ACC_W       35
`define MAC_EXT_W       3
`define MAC_WORD_W      16
`define MAC_ROUND_BIT   15
`define MAC_ADR_W       3
`define MAC_DATA_W      32
`define MAC_REG_CTRL    3'h0
`define MAC_REG_ACC_LO  3'h1
`define MAC_REG_ACC_EXT 3'h2
`define MAC_REG_OPND    3'h3
`define MAC_REG_INSTR   3'h4
`define MAC_CTRL_HOLD   0
`define MAC_SEC_LOW     0
`define MAC_SEC_UPPER   1
`define MAC_SEC_EXT     2
`endif

// file: logic/mac_pkg.sv
// types shared by the multiplier accumulator modules
`include "mac_consts.svh"
package mac_pkg;
  typedef struct packed {
    logic signed_select;
    logic round_enable;
    logic sum_mode_select;
    logic minus_select;
  } mac_instr_t;
  typedef struct packed {
    logic [`MAC_EXT_W-1:0]  ext;
    logic [`MAC_WORD_W-1:0] upper;
    logic [`MAC_WORD_W-1:0] low;
  } mac_acc_t;
  // pin bundle that crosses into the CLK domain
  typedef struct packed {
    logic                   x_clk;
    logic                   y_clk;
    logic                   p_clk;
    mac_instr_t             instr;
    logic                   load_mode;
    logic [2:0]             sec_en;
    logic [`MAC_OPND_W-1:0] x_data;
    logic [`MAC_OPND_W-1:0] y_data;
    logic [`MAC_EXT_W-1:0]  ext_data;
    logic [`MAC_WORD_W-1:0] upper_data;
  } mac_pins_t;
  typedef enum logic [1:0] {
    MAC_OP_LOAD    = 2'b00,
    MAC_OP_ADD     = 2'b01,
    MAC_OP_SUB     = 2'b10,
    MAC_OP_PRELOAD = 2'b11
  } mac_op_t;
  typedef enum logic {
    MAC_BUS_IDLE = 1'b0,
    MAC_BUS_DONE = 1'b1
  } mac_bus_t;
  typedef struct packed {
    logic [2:0]             clk_prev;
    logic [`MAC_OPND_W-1:0] x_reg;
    logic [`MAC_OPND_W-1:0] y_reg;
    mac_instr_t             instr;
    mac_acc_t               acc;
    logic [2:0]             oe;
    logic                   hold;
    mac_bus_t               bus;
    logic [`MAC_DATA_W-1:0] rdata;
  } mac_state_t;
endpackage : mac_pkg

// file: logic/mac_sync.sv
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
module mac_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } mac_sync_t;
  mac_sync_t r;
  mac_sync_t next_r;
  // first stage feeds only the second stage
  always_comb begin
    next_r    = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign dout = r.s2;
endmodule : mac_sync

// file: logic/mac_mult.sv
// 16x16 multiplier with rounding and extension to accumulator width
`timescale 1ns/100ps
`include "mac_consts.svh"
module mac_mult (
  input  wire logic [`MAC_OPND_W-1:0] x,
  input  wire logic [`MAC_OPND_W-1:0] y,
  input  wire logic                   signed_select,
  input  wire logic                   round_enable,
  output logic      [`MAC_ACC_W-1:0]  product
);
  logic signed [`MAC_OPND_W:0]     xe;
  logic signed [`MAC_OPND_W:0]     ye;
  logic signed [2*`MAC_OPND_W+1:0] raw;
  logic        [`MAC_ACC_W-1:0]    round_add;
  // one extra top bit makes a single signed multiplier serve both modes
  always_comb begin
    xe  = {signed_select & x[`MAC_OPND_W-1], x};
    ye  = {signed_select & y[`MAC_OPND_W-1], y};
    raw = xe * ye;
    round_add = '0;
    round_add[`MAC_ROUND_BIT] = round_enable;
    // unsigned products never set the top bit, so this is also zero fill
    product = {raw[2*`MAC_OPND_W+1], raw} + round_add;
  end
endmodule : mac_mult

// file: logic/mac_core.sv
// 16x16 multiplier accumulator core with pin sampling and register bus
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`include "mac_consts.svh"
module mac_core (
  input  wire logic                   CLK,
  input  wire logic                   RESET_N,
  input  wire logic [`MAC_OPND_W-1:0] X_IN,
  input  wire logic [`MAC_WORD_W-1:0] LOW_IN,
  output logic      [`MAC_WORD_W-1:0] LOW_OUT,
  output logic                        LOW_OE,
  input  wire logic [`MAC_WORD_W-1:0] UPPER_IN,
  output logic      [`MAC_WORD_W-1:0] UPPER_OUT,
  output logic                        UPPER_OE,
  input  wire logic [`MAC_EXT_W-1:0]  EXT_IN,
  output logic      [`MAC_EXT_W-1:0]  EXT_OUT,
  output logic                        EXT_OE,
  input  wire logic                   SIGNED_SELECT,
  input  wire logic                   ROUND_ENABLE,
  input  wire logic                   SUM_MODE_SELECT,
  input  wire logic                   MINUS_SELECT,
  input  wire logic                   PORT_LOAD_MODE,
  input  wire logic                   EXT_PORT_ENABLE,
  input  wire logic                   UPPER_PORT_ENABLE,
  input  wire logic                   LOW_PORT_ENABLE,
  input  wire logic                   X_OPERAND_CLOCK,
  input  wire logic                   Y_OPERAND_CLOCK,
  input  wire logic                   PRODUCT_CLOCK,
  input  wire logic [`MAC_ADR_W-1:0]  AVS_ADDRESS,
  input  wire logic                   AVS_READ,
  input  wire logic                   AVS_WRITE,
  input  wire logic [3:0]             AVS_BYTEENABLE,
  input  wire logic [`MAC_DATA_W-1:0] AVS_WRITEDATA,
  output logic      [`MAC_DATA_W-1:0] AVS_READDATA,
  output logic                        AVS_WAITREQUEST
);

  mac_pkg::mac_pins_t  pin_raw;
  mac_pkg::mac_pins_t  s;
  mac_pkg::mac_state_t r;
  mac_pkg::mac_state_t next_r;
  mac_pkg::mac_op_t    op;
  logic [`MAC_ACC_W-1:0] product;
  logic [`MAC_ACC_W-1:0] acc_flat;
  logic [`MAC_ACC_W-1:0] acc_sum;
  logic [`MAC_ACC_W-1:0] acc_diff;
  logic [`MAC_DATA_W-1:0] rd_mux;
  logic x_rise;
  logic y_rise;
  logic p_rise;
  logic p_go;
  logic bus_req;
  logic wr_take;

  // gather every pin level except clock, reset and the bus into one bundle before the crossing
  always_comb begin
    pin_raw                       = '0;
    pin_raw.x_clk                 = X_OPERAND_CLOCK;
    pin_raw.y_clk                 = Y_OPERAND_CLOCK;
    pin_raw.p_clk                 = PRODUCT_CLOCK;
    pin_raw.instr.signed_select   = SIGNED_SELECT;
    pin_raw.instr.round_enable    = ROUND_ENABLE;
    pin_raw.instr.sum_mode_select = SUM_MODE_SELECT;
    pin_raw.instr.minus_select    = MINUS_SELECT;
    pin_raw.load_mode             = PORT_LOAD_MODE;
    pin_raw.sec_en[`MAC_SEC_EXT]   = EXT_PORT_ENABLE;
    pin_raw.sec_en[`MAC_SEC_UPPER] = UPPER_PORT_ENABLE;
    pin_raw.sec_en[`MAC_SEC_LOW]   = LOW_PORT_ENABLE;
    pin_raw.x_data                = X_IN;
    pin_raw.y_data                = LOW_IN;
    pin_raw.ext_data              = EXT_IN;
    pin_raw.upper_data            = UPPER_IN;
  end

  // data and clocks share one delay, so setup relations at the pins
  // survive the crossing; pin clocks must stay well below CLK/4
  mac_sync #(
    .WIDTH ($bits(mac_pkg::mac_pins_t))
  ) u_sync (
    .clk     (CLK),
    .reset_n (RESET_N),
    .din     (pin_raw),
    .dout    (s)
  );

  // multiplier works on the registered operands and instruction
  mac_mult u_mult (
    .x             (r.x_reg),
    .y             (r.y_reg),
    .signed_select (r.instr.signed_select),
    .round_enable  (r.instr.round_enable),
    .product       (product)
  );

  // rising edges of the sampled pin clocks become one-cycle enables
  always_comb begin
    x_rise = s.x_clk & ~r.clk_prev[2];
    y_rise = s.y_clk & ~r.clk_prev[1];
    p_rise = s.p_clk & ~r.clk_prev[0];
    p_go   = p_rise & ~r.hold;
  end

  // accumulator function selected at the product clock edge
  always_comb begin
    if (s.load_mode) begin
      op = mac_pkg::MAC_OP_PRELOAD;
    end else if (!r.instr.sum_mode_select) begin
      op = mac_pkg::MAC_OP_LOAD;
    end else if (r.instr.minus_select) begin
      op = mac_pkg::MAC_OP_SUB;
    end else begin
      op = mac_pkg::MAC_OP_ADD;
    end
  end

  // both results stay 35 bits; overflow wraps, there is no saturation
  always_comb begin
    acc_flat = r.acc;
    acc_sum  = product + acc_flat;
    acc_diff = product - acc_flat;
  end

  // bus request and register read mux
  always_comb begin
    bus_req = AVS_READ | AVS_WRITE;
    wr_take = AVS_WRITE & (r.bus == mac_pkg::MAC_BUS_DONE);
    rd_mux  = '0;
    if (AVS_ADDRESS == `MAC_REG_CTRL) begin
      rd_mux[`MAC_CTRL_HOLD] = r.hold;
    end else if (AVS_ADDRESS == `MAC_REG_ACC_LO) begin
      rd_mux = {r.acc.upper, r.acc.low};
    end else if (AVS_ADDRESS == `MAC_REG_ACC_EXT) begin
      rd_mux[`MAC_EXT_W-1:0] = r.acc.ext;
    end else if (AVS_ADDRESS == `MAC_REG_OPND) begin
      rd_mux = {r.x_reg, r.y_reg};
    end else if (AVS_ADDRESS == `MAC_REG_INSTR) begin
      rd_mux[3:0] = r.instr;
    end else begin
      rd_mux = '0;                     // unmapped reads as zero
    end
  end

  // next state of the whole core
  always_comb begin
    next_r          = r;
    next_r.clk_prev = {s.x_clk, s.y_clk, s.p_clk};
    // operand and instruction capture
    if (x_rise) begin
      next_r.x_reg = s.x_data;
    end
    if (y_rise) begin
      next_r.y_reg = s.y_data;
    end
    if (x_rise | y_rise) begin
      next_r.instr = s.instr;
    end
    // accumulator update, only on a product clock edge
    if (p_go) begin
      case (op)
        mac_pkg::MAC_OP_LOAD: begin
          next_r.acc = product;
        end
        mac_pkg::MAC_OP_ADD: begin
          next_r.acc = acc_sum;
        end
        mac_pkg::MAC_OP_SUB: begin
          next_r.acc = acc_diff;
        end
        default: begin
          // host keeps the pins steady over this edge
          if (s.sec_en[`MAC_SEC_EXT]) begin
            next_r.acc.ext = s.ext_data;
          end
          if (s.sec_en[`MAC_SEC_UPPER]) begin
            next_r.acc.upper = s.upper_data;
          end
          if (s.sec_en[`MAC_SEC_LOW]) begin
            next_r.acc.low = s.y_data;
          end
          // sections left disabled keep their value
        end
      endcase
    end
    // registered output enables, off for the whole preload
    next_r.oe = ~s.sec_en & {3{~s.load_mode}};
    // bus: one wait cycle, then answer
    case (r.bus)
      mac_pkg::MAC_BUS_IDLE: begin
        if (bus_req) begin
          next_r.bus   = mac_pkg::MAC_BUS_DONE;
          next_r.rdata = AVS_READ ? rd_mux : '0;
        end
      end
      default: begin
        next_r.bus = mac_pkg::MAC_BUS_IDLE;
        if (wr_take && AVS_ADDRESS == `MAC_REG_CTRL && AVS_BYTEENABLE[0]) begin
          next_r.hold = AVS_WRITEDATA[`MAC_CTRL_HOLD];
        end
      end
    endcase
  end

  // single register stage for all state
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops, except waitrequest below
  assign EXT_OUT         = r.acc.ext;
  assign UPPER_OUT       = r.acc.upper;
  assign LOW_OUT         = r.acc.low;
  assign EXT_OE          = r.oe[`MAC_SEC_EXT];
  assign UPPER_OE        = r.oe[`MAC_SEC_UPPER];
  assign LOW_OE          = r.oe[`MAC_SEC_LOW];
  assign AVS_READDATA    = r.rdata;
  // waitrequest is combinational so a master sees it in the request cycle
  assign AVS_WAITREQUEST = bus_req & (r.bus == mac_pkg::MAC_BUS_IDLE);

  // checks on operand, accumulator, port and bus behaviour
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence bus_wait_s;
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endsequence

  sequence preload_edge_s;
    p_go && s.load_mode;
  endsequence

  x_operand_load_a: assert property (
    x_rise |=> r.x_reg == $past(s.x_data))
    else $error("x operand not loaded on x clock edge");

  y_operand_load_a: assert property (
    y_rise |=> r.y_reg == $past(s.y_data))
    else $error("y operand not loaded on y clock edge");

  instr_capture_a: assert property (
    (x_rise || y_rise) |=> r.instr == $past(s.instr))
    else $error("instruction not captured on operand clock edge");

  instr_hold_a: assert property (
    !(x_rise || y_rise) |=> $stable(r.instr))
    else $error("instruction changed without operand clock edge");

  acc_overwrite_a: assert property (
    p_go && !s.load_mode && !r.instr.sum_mode_select
    |=> r.acc == $past(product))
    else $error("accumulator not overwritten by product");

  acc_add_a: assert property (
    p_go && !s.load_mode && r.instr.sum_mode_select
    && !r.instr.minus_select
    |=> r.acc == $past(product) + $past(acc_flat))
    else $error("accumulate add result wrong");

  acc_sub_a: assert property (
    p_go && !s.load_mode && r.instr.sum_mode_select
    && r.instr.minus_select
    |=> r.acc == $past(product) - $past(acc_flat))
    else $error("accumulate subtract result wrong");

  acc_idle_a: assert property (
    !p_go |=> $stable(r.acc))
    else $error("accumulator changed without product clock edge");

  preload_low_a: assert property (
    preload_edge_s and s.sec_en[`MAC_SEC_LOW]
    |=> r.acc.low == $past(s.y_data))
    else $error("low section not preloaded");

  preload_keep_a: assert property (
    preload_edge_s and !s.sec_en[`MAC_SEC_UPPER]
    |=> $stable(r.acc.upper))
    else $error("disabled upper section changed in preload");

  port_off_a: assert property (
    s.load_mode |=> !EXT_OE && !UPPER_OE && !LOW_OE)
    else $error("product port driven during preload");

  port_drive_a: assert property (
    !s.load_mode && !s.sec_en[`MAC_SEC_UPPER] |=> UPPER_OE)
    else $error("upper port not driven while enabled");

  unsigned_fill_a: assert property (
    !r.instr.signed_select |-> product[`MAC_ACC_W-1:`MAC_ACC_W-3] == 3'h0)
    else $error("unsigned product not zero filled");

  signed_ext_a: assert property (
    r.instr.signed_select
    |-> product[`MAC_ACC_W-1:`MAC_ACC_W-3] == {3{product[`MAC_ACC_W-1]}})
    else $error("signed product not sign extended");

  bus_answer_a: assert property (
    bus_req && r.bus == mac_pkg::MAC_BUS_IDLE |-> bus_wait_s)
    else $error("bus answer not after one wait cycle");

  preload_ext_a: assert property (
    preload_edge_s and s.sec_en[`MAC_SEC_EXT]
    |=> r.acc.ext == $past(s.ext_data))
    else $error("ext section not preloaded");

  preload_upper_a: assert property (
    preload_edge_s and s.sec_en[`MAC_SEC_UPPER]
    |=> r.acc.upper == $past(s.upper_data))
    else $error("upper section not preloaded");

  keep_low_a: assert property (
    preload_edge_s and !s.sec_en[`MAC_SEC_LOW]
    |=> $stable(r.acc.low))
    else $error("disabled low section changed in preload");

  keep_ext_a: assert property (
    preload_edge_s and !s.sec_en[`MAC_SEC_EXT]
    |=> $stable(r.acc.ext))
    else $error("disabled ext section changed in preload");

  port_drive_low_a: assert property (
    !s.load_mode && !s.sec_en[`MAC_SEC_LOW] |=> LOW_OE)
    else $error("low port not driven while enabled");

  acc_freeze_a: assert property (
    p_rise && r.hold |=> $stable(r.acc))
    else $error("frozen accumulator changed on product clock");

endmodule : mac_core

// file: tb/mac_host_model.sv
// host-side model of the three shared product port sections
`timescale 1ns/100ps
module mac_host_model (
  input  wire logic              clk,
  input  wire logic [2:0]        dev_oe,
  input  wire mac_pkg::mac_acc_t dev_out,
  input  wire logic [2:0]        host_en,
  input  wire mac_pkg::mac_acc_t host_val,
  output mac_pkg::mac_acc_t      pin_val
);
  mac_pkg::mac_acc_t last;

  // released sections show the inverse of the last level, so a stale copy never passes
  always_comb begin
    pin_val.ext   = dev_oe[2] ? dev_out.ext :
                    host_en[2] ? host_val.ext : ~last.ext;
    pin_val.upper = dev_oe[1] ? dev_out.upper :
                    host_en[1] ? host_val.upper : ~last.upper;
    pin_val.low   = dev_oe[0] ? dev_out.low :
                    host_en[0] ? host_val.low : ~last.low;
  end

  // remember the wire level for the released case
  always_ff @(posedge clk) begin
    last <= pin_val;
  end
endmodule : mac_host_model

// file: tb/tb_mac_16x16_accumulator.sv
// self-checking bench for the multiplier accumulator core
`timescale 1ns/100ps
`include "mac_consts.svh"
module tb_mac_16x16_accumulator;
  logic                clk;
  logic                reset_n;
  logic [15:0]         x_in;
  logic [2:0]          pclk;
  mac_pkg::mac_instr_t instr;
  logic                load_mode;
  logic [2:0]          sec_en;
  logic [2:0]          host_en;
  mac_pkg::mac_acc_t   host_val;
  wire mac_pkg::mac_acc_t pin_val;
  wire mac_pkg::mac_acc_t dev_out;
  wire logic [2:0]     dev_oe;
  logic [2:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_writedata;
  wire logic [31:0]    avs_readdata;
  wire logic           avs_waitrequest;
  int                  num_errors;
  int                  compares;
  logic [34:0]         acc_exp;
  logic [31:0]         rd;
  logic [15:0]         xs [6] = '{16'hffff, 16'hffff, 16'h8000, 16'h1234, 16'h8000, 16'h0001};
  logic [15:0]         ys [6] = '{16'hffff, 16'hffff, 16'h7fff, 16'h5678, 16'h8000, 16'h0003};
  logic [3:0]          iv [6] = '{4'b0000, 4'b1100, 4'b1010, 4'b0011, 4'b1110, 4'b1001};

  mac_core mac_core_inst (
    .CLK(clk), .RESET_N(reset_n), .X_IN(x_in),
    .LOW_IN(pin_val.low), .LOW_OUT(dev_out.low), .LOW_OE(dev_oe[0]),
    .UPPER_IN(pin_val.upper), .UPPER_OUT(dev_out.upper), .UPPER_OE(dev_oe[1]),
    .EXT_IN(pin_val.ext), .EXT_OUT(dev_out.ext), .EXT_OE(dev_oe[2]),
    .SIGNED_SELECT(instr.signed_select), .ROUND_ENABLE(instr.round_enable),
    .SUM_MODE_SELECT(instr.sum_mode_select), .MINUS_SELECT(instr.minus_select),
    .PORT_LOAD_MODE(load_mode), .EXT_PORT_ENABLE(sec_en[2]),
    .UPPER_PORT_ENABLE(sec_en[1]), .LOW_PORT_ENABLE(sec_en[0]),
    .X_OPERAND_CLOCK(pclk[0]), .Y_OPERAND_CLOCK(pclk[1]), .PRODUCT_CLOCK(pclk[2]),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_BYTEENABLE(avs_byteenable), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest)
  );

  mac_host_model mac_host_model_inst (
    .clk(clk), .dev_oe(dev_oe), .dev_out(dev_out),
    .host_en(host_en), .host_val(host_val), .pin_val(pin_val)
  );

  // free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic conclude();
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one avalon transfer; the request stands until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [2:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_byteenable <= be;
    avs_writedata <= wd;
    // a stuck slave is ended by the watchdog, not here
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : avs

  // pin clocks get five CLK cycles high and low, above the two-cycle minimum
  task automatic tick(input logic [2:0] m);
    @(posedge clk);
    pclk <= m;
    repeat (5) @(posedge clk);
    pclk <= 3'b000;
    repeat (5) @(posedge clk);
  endtask : tick

  function automatic logic [34:0] product(input logic [15:0] x, y, input logic sg, rounding);
    logic [34:0] a;
    logic [34:0] b;
    a = sg ? {{19{x[15]}}, x} : {19'h0, x};
    b = sg ? {{19{y[15]}}, y} : {19'h0, y};
    return a * b + (rounding ? 35'h0000_8000 : 35'h0);
  endfunction : product

  // compare the accumulator through the bus and through the driven ports
  task automatic chk_acc();
    avs(1'b0, `MAC_REG_ACC_LO, 4'hf, 32'h0);
    check("acc_lo", {3'h0, rd}, {3'h0, acc_exp[31:0]});
    avs(1'b0, `MAC_REG_ACC_EXT, 4'hf, 32'h0);
    check("acc_ext", {3'h0, rd}, {32'h0, acc_exp[34:32]});
    sec_en <= 3'b000;
    repeat (5) @(posedge clk);
    check("ports", pin_val, acc_exp);
    check("oe_on", {32'h0, dev_oe}, 35'h7);
    sec_en <= 3'b111;
    repeat (5) @(posedge clk);
    check("oe_off", {32'h0, dev_oe}, 35'h0);
  endtask : chk_acc

  // preload through the ports; sections left disabled keep their value
  task automatic preload(input logic [2:0] en, input logic [34:0] val);
    @(posedge clk);
    load_mode <= 1'b1;
    sec_en <= en;
    host_val <= val;
    host_en <= 3'h7;
    repeat (5) @(posedge clk);
    check("oe_preload", {32'h0, dev_oe}, 35'h0);
    tick(3'h4);
    host_en <= 3'h0;
    load_mode <= 1'b0;
    if (en[2]) acc_exp[34:32] = val[34:32];
    if (en[1]) acc_exp[31:16] = val[31:16];
    if (en[0]) acc_exp[15:0] = val[15:0];
    chk_acc();
  endtask : preload

  task automatic mac_op(input logic [15:0] x, y, input logic [3:0] ins, input logic upd);
    logic [34:0] p;
    mac_pkg::mac_instr_t i;
    i = ins;
    @(posedge clk);
    x_in <= x;
    host_val.low <= y;
    host_en <= 3'b001;
    instr <= i;
    tick(3'b011);
    host_en <= 3'b000;
    tick(3'b100);
    p = product(x, y, i.signed_select, i.round_enable);
    // a frozen accumulator keeps its value
    if (upd && !i.sum_mode_select) begin
      acc_exp = p;
    end else if (upd && i.minus_select) begin
      acc_exp = p - acc_exp;
    end else if (upd) begin
      acc_exp = p + acc_exp;
    end
    avs(1'b0, `MAC_REG_OPND, 4'hf, 32'h0);
    check("operands", {3'h0, rd}, {3'h0, x, y});
    avs(1'b0, `MAC_REG_INSTR, 4'hf, 32'h0);
    check("instr", {3'h0, rd}, {31'h0, ins});
    chk_acc();
  endtask : mac_op

  // cut a hang short well beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end

  initial begin
    reset_n = 1'b0;
    x_in = 16'h0;
    pclk = 3'b000;
    instr = 4'h0;
    load_mode = 1'b0;
    sec_en = 3'b111;
    host_en = 3'b000;
    host_val = 35'h0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
    num_errors = 0;
    compares = 0;
    acc_exp = 35'h0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    chk_acc();
    for (int k = 0; k < 6; k++) begin
      if (k == 3) begin
        // ext and low only; upper pins carry data but are not enabled
        preload(3'h5, {3'h5, 16'h1357, 16'habcd});
      end
      mac_op(xs[k], ys[k], iv[k], 1'b1);
    end
    // freeze control needs byte lane 0; a frozen accumulator ignores the product clock
    avs(1'b1, `MAC_REG_CTRL, 4'h0, 32'h1);
    avs(1'b0, `MAC_REG_CTRL, 4'hf, 32'h0);
    check("ctrl_lane", {3'h0, rd}, 35'h0);
    avs(1'b1, `MAC_REG_CTRL, 4'h1, 32'h1);
    avs(1'b0, `MAC_REG_CTRL, 4'hf, 32'h0);
    check("ctrl_set", {3'h0, rd}, 35'h1);
    mac_op(16'h7777, 16'h0005, 4'b0010, 1'b0);
    avs(1'b1, `MAC_REG_CTRL, 4'h1, 32'h0);
    avs(1'b1, 3'h7, 4'hf, 32'h1234_5678);
    avs(1'b0, 3'h7, 4'hf, 32'h0);
    check("unmapped", {3'h0, rd}, 35'h0);
    mac_op(16'h0003, 16'h0007, 4'h2, 1'b1);
    // upper only, so ext and low must keep their contents
    preload(3'h2, {3'h2, 16'h2468, 16'h0f0f});
    mac_op(16'hfff0, 16'h0010, 4'ha, 1'b1);
    // a reset in mid-run clears accumulator, operands and instruction
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    acc_exp = 35'h0;
    chk_acc();
    avs(1'b0, `MAC_REG_OPND, 4'hf, 32'h0);
    check("opnd_reset", {3'h0, rd}, 35'h0);
    avs(1'b0, `MAC_REG_INSTR, 4'hf, 32'h0);
    check("instr_reset", {3'h0, rd}, 35'h0);
    conclude();
  end
endmodule : tb_mac_16x16_accumulator
